/* pdam_pkg.sv */
// Behaviour
// [R1] Program address 24 bits from pointer or table
// [R2] Program space spans 4M instruction locations
// [R3] User access limited to lower half
// [R4] Table page bit 7 opens configuration space
// [R5] Even lower word, odd upper, top byte empty (code returns all 24 bits at an even address)
// [R6] Pointer aligned, steps by two per instruction
// [R7] Low region reserved for fixed vectors
// [R8] Reset starts execution at address zero
// [R9] Primary and alternate interrupt vector tables
// [R10] Separate read and write address generators
// [R11] Byte-granular 16-bit data addresses, 64 Kbytes
// [R12] Bit 15 selects program window view
// [R13] Beyond implemented data memory reads zero
// [R14] Low byte even, high byte odd
// [R15] Byte read selects byte onto low lane
// [R16] Odd word access traps, write suppressed
// [R17] Unimplemented user program space reads zero
package pdam_pkg;
  localparam logic [23:0] PDAM_RESET_VECTOR   = 24'h000000;
  localparam logic [23:0] PDAM_START_ADDR_LOC = 24'h000002;
  localparam logic [23:0] PDAM_PRIMARY_IVT    = 24'h000004;
  localparam logic [23:0] PDAM_ALT_IVT_LO     = 24'h000100;
  localparam logic [23:0] PDAM_ALT_IVT_HI     = 24'h0001FF;
  localparam logic [23:0] PDAM_VECTOR_END     = 24'h000200;
  localparam logic [23:0] PDAM_USER_TOP       = 24'h7FFFFF;
  localparam logic [23:0] PDAM_FLASH_END      = 24'h02AC00;
  localparam logic [23:0] PDAM_CONFIG_BASE    = 24'hF80000;
  localparam logic [23:0] PDAM_CONFIG_END     = 24'hF80018;
  localparam logic [23:0] PDAM_PART_ID_BASE   = 24'hFF0000;
  localparam int          PDAM_PAGE_CFG_BIT   = 7;
  localparam int          PDAM_WINDOW_BIT     = 15;
  localparam logic [15:0] PDAM_DATA_IMPL_END  = 16'h4000;
  localparam logic [23:0] PDAM_PTR_STEP       = 24'h000002;

  typedef enum logic [1:0] {
    PDAM_REG_VECTOR   = 2'h0,
    PDAM_REG_FLASH    = 2'h1,
    PDAM_REG_CONFIG   = 2'h2,
    PDAM_REG_NONE     = 2'h3
  } pdam_region_t;

  typedef struct packed {
    logic        valid;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pdam_data_req_t;

  typedef struct packed {
    logic        ram_sel;
    logic        window_sel;
    logic        zero_fill;
    logic        addr_error;
    logic [15:0] rdata;
  } pdam_data_rsp_t;
endpackage : pdam_pkg

/* pdam_map.sv */
module pdam_map (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    step_fwd,
  input  wire logic                    step_back,
  input  wire logic                    load_ptr,
  input  wire logic [22:0]             load_target,
  input  wire logic                    table_op,
  input  wire logic [7:0]              table_page_select,
  input  wire logic [15:0]             table_offset,
  input  wire logic [23:0]             prog_rdata,
  input  wire pdam_pkg::pdam_data_req_t rd_req,
  input  wire pdam_pkg::pdam_data_req_t wr_req,
  input  wire logic [15:0]             mem_rdata,
  output logic [22:0]                  instruction_pointer,
  output logic [23:0]                  prog_addr,
  output logic                         prog_allowed,
  output logic [1:0]                   prog_region,
  output logic [23:0]                  prog_data,
  output pdam_pkg::pdam_data_rsp_t     rd_rsp,
  output logic [15:0]                  mem_raddr,
  output logic [15:0]                  mem_waddr,
  output logic [1:0]                   mem_wbe,
  output logic [15:0]                  mem_wdata,
  output logic                         addr_error_trap
);
  import pdam_pkg::*;

  logic [22:0] ptr_reg, ptr_next;
  logic [23:0] addr_c;
  logic        cfg_open, in_cfg;
  pdam_region_t region_c;
  pdam_data_rsp_t rsp_reg, rsp_next;
  logic [15:0] waddr_reg, waddr_next, wdata_reg, wdata_next;
  logic [1:0]  wbe_reg, wbe_next;
  logic        trap_reg, trap_next;
  logic [23:0] pdata_reg, pdata_next;

  // Instruction pointer: lower-word aligned, steps of two
  always_comb
  begin
    ptr_next = ptr_reg;
    if (load_ptr)
      ptr_next = {load_target[22:1], 1'b0}; // see [R6]
    else if (step_fwd)
      ptr_next = ptr_reg + PDAM_PTR_STEP[22:0]; // see [R6]
    else if (step_back)
      ptr_next = ptr_reg - PDAM_PTR_STEP[22:0]; // see [R6]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ptr_reg <= PDAM_RESET_VECTOR[22:0]; // see [R8]
    else
      ptr_reg <= ptr_next;
  end

  assign instruction_pointer = ptr_reg;

  // 24-bit program address and its decode
  always_comb
  begin
    addr_c = table_op ? {table_page_select, table_offset} : {1'b0, ptr_reg}; // see [R1] [R2]
    cfg_open = table_op && table_page_select[PDAM_PAGE_CFG_BIT]; // see [R4]
    in_cfg = ((addr_c >= PDAM_CONFIG_BASE) && (addr_c < PDAM_CONFIG_END))
             || (addr_c >= PDAM_PART_ID_BASE);
    if (addr_c < PDAM_VECTOR_END)
      region_c = PDAM_REG_VECTOR; // see [R7] [R9]
    else if (addr_c < PDAM_FLASH_END)
      region_c = PDAM_REG_FLASH;
    else if (cfg_open && in_cfg)
      region_c = PDAM_REG_CONFIG;
    else
      region_c = PDAM_REG_NONE;
  end

  assign prog_addr = addr_c;
  assign prog_allowed = (addr_c <= PDAM_USER_TOP) || (cfg_open && in_cfg); // see [R3] [R4]
  assign prog_region = region_c;

  // Fetch data: odd word's top byte empty, holes read zero
  always_comb
  begin
    pdata_next = 24'h000000;
    if (region_c != PDAM_REG_NONE)
      pdata_next = prog_rdata; // see [R17]
    if (table_op && addr_c[0])
      pdata_next = {8'h00, 8'h00, pdata_next[23:16]}; // see [R5]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pdata_reg <= 24'h000000;
    else
      pdata_reg <= pdata_next;
  end

  assign prog_data = pdata_reg;

  // Read address generator
  assign mem_raddr = {rd_req.addr[15:1], 1'b0}; // see [R10] [R15]

  always_comb
  begin
    rsp_next = '0;
    if (rd_req.valid)
    begin
      rsp_next.window_sel = rd_req.addr[PDAM_WINDOW_BIT]; // see [R12]
      rsp_next.ram_sel = !rd_req.addr[PDAM_WINDOW_BIT]
                         && (rd_req.addr < PDAM_DATA_IMPL_END); // see [R11] [R13]
      rsp_next.zero_fill = !rd_req.addr[PDAM_WINDOW_BIT] && !rsp_next.ram_sel;
      rsp_next.addr_error = rd_req.word && rd_req.addr[0]; // see [R16]
      if (rsp_next.ram_sel)
      begin
        if (rd_req.word)
          rsp_next.rdata = mem_rdata; // see [R14]
        else
          rsp_next.rdata = {8'h00, rd_req.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]}; // see [R15]
      end
    end
  end

  // Write address generator; its trap also takes the read address error
  always_comb
  begin
    waddr_next = {wr_req.addr[15:1], 1'b0}; // see [R10]
    wdata_next = wr_req.wdata;
    wbe_next = 2'b00;
    trap_next = rsp_next.addr_error;
    if (wr_req.valid && !wr_req.addr[PDAM_WINDOW_BIT]
        && (wr_req.addr < PDAM_DATA_IMPL_END))
    begin
      if (wr_req.word)
        wbe_next = wr_req.addr[0] ? 2'b00 : 2'b11; // see [R16]
      else
      begin
        wbe_next = wr_req.addr[0] ? 2'b10 : 2'b01; // see [R14]
        wdata_next = {wr_req.wdata[7:0], wr_req.wdata[7:0]};
      end
    end
    if (wr_req.valid && wr_req.word && wr_req.addr[0])
      trap_next = 1'b1; // see [R16]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rsp_reg   <= '0;
      waddr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      wbe_reg   <= 2'b00;
      trap_reg  <= 1'b0;
    end
    else
    begin
      rsp_reg   <= rsp_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wbe_reg   <= wbe_next;
      trap_reg  <= trap_next;
    end
  end

  assign rd_rsp = rsp_reg;
  assign mem_waddr = waddr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_wbe = wbe_reg;
  assign addr_error_trap = trap_reg;

  property p_reset_vector;
    @(posedge clk) reset |=> (instruction_pointer == 23'h000000);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("pointer not at reset vector"); // see [R8]

  property p_step_two;
    @(posedge clk) disable iff (reset)
      (!load_ptr && step_fwd) |=> (instruction_pointer == $past(instruction_pointer) + 23'h000002);
  endproperty
  a_step_two: assert property (p_step_two) else $error("pointer did not step by two"); // see [R6]

  property p_aligned;
    @(posedge clk) disable iff (reset) ##1 (instruction_pointer[0] == 1'b0);
  endproperty
  a_aligned: assert property (p_aligned) else $error("pointer misaligned"); // see [R6]

  property p_user_half;
    @(posedge clk) disable iff (reset) (prog_addr[23] && !table_op) |-> !prog_allowed;
  endproperty
  a_user_half: assert property (p_user_half) else $error("upper half reached by user"); // see [R3]

  property p_cfg_gate;
    @(posedge clk) disable iff (reset)
      (prog_region == 2'h2) |-> (table_op && table_page_select[7]);
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config reached without page bit"); // see [R4]

  property p_hole_zero;
    @(posedge clk) disable iff (reset) (prog_region == 2'h3) |=> (prog_data == 24'h000000);
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("hole did not read zero"); // see [R17]

  property p_data_zero;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && !rd_req.addr[15] && (rd_req.addr >= 16'h4000))
      |=> (rd_rsp.rdata == 16'h0000 && rd_rsp.zero_fill);
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("unimplemented read not zero"); // see [R13]

  property p_window;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && rd_req.addr[15]) |=> (rd_rsp.window_sel && !rd_rsp.ram_sel);
  endproperty
  a_window: assert property (p_window) else $error("window not selected"); // see [R12]

  property p_byte_lane;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && !rd_req.word && rd_req.addr < 16'h4000 && rd_req.addr[0])
      |=> (rd_rsp.rdata == {8'h00, $past(mem_rdata[15:8])});
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("odd byte not on low lane"); // see [R15]

  property p_misaligned_write;
    @(posedge clk) disable iff (reset)
      (wr_req.valid && wr_req.word && wr_req.addr[0]) |=> (addr_error_trap && mem_wbe == 2'b00);
  endproperty
  a_misaligned_write: assert property (p_misaligned_write) else $error("odd word write not trapped"); // see [R16]

  property p_step_back;
    @(posedge clk) disable iff (reset)
      (!load_ptr && !step_fwd && step_back)
      |=> (instruction_pointer == $past(instruction_pointer) - 23'h000002);
  endproperty
  a_step_back: assert property (p_step_back) else $error("pointer did not step back by two"); // see [R6]

  property p_load_aligned;
    @(posedge clk) disable iff (reset)
      load_ptr
      |=> (instruction_pointer == {$past(load_target[22:1]), 1'b0});
  endproperty
  a_load_aligned: assert property (p_load_aligned) else $error("jump target not aligned"); // see [R6]

  property p_ptr_hold;
    @(posedge clk) disable iff (reset)
      (!load_ptr && !step_fwd && !step_back)
      |=> $stable(instruction_pointer);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved while idle"); // see [R6]

  property p_fetch_addr;
    @(posedge clk) disable iff (reset)
      !table_op
      |-> (prog_addr == {1'b0, instruction_pointer});
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not from pointer"); // see [R1]

  property p_table_addr;
    @(posedge clk) disable iff (reset)
      table_op
      |-> (prog_addr == {table_page_select, table_offset});
  endproperty
  a_table_addr: assert property (p_table_addr) else $error("table address not from page"); // see [R1]

  property p_vector_region;
    @(posedge clk) disable iff (reset)
      (prog_addr < 24'h000200)
      |-> (prog_region == 2'h0);
  endproperty
  a_vector_region: assert property (p_vector_region) else $error("vector area not decoded"); // see [R7]

  property p_cfg_open;
    @(posedge clk) disable iff (reset)
      (table_op && table_page_select[7] && prog_addr >= 24'hF80000 && prog_addr < 24'hF80018)
      |-> (prog_allowed && prog_region == 2'h2);
  endproperty
  a_cfg_open: assert property (p_cfg_open) else $error("config space not opened"); // see [R4]

  property p_upper_byte;
    @(posedge clk) disable iff (reset)
      (table_op && prog_addr[0] && prog_region != 2'h3)
      |=> (prog_data == {16'h0000, $past(prog_rdata[23:16])});
  endproperty
  a_upper_byte: assert property (p_upper_byte) else $error("upper word not returned"); // see [R5]

  property p_raddr;
    @(posedge clk) disable iff (reset)
      rd_req.valid
      |-> (mem_raddr == {rd_req.addr[15:1], 1'b0});
  endproperty
  a_raddr: assert property (p_raddr) else $error("read address not word aligned"); // see [R10]

  property p_word_read;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && rd_req.word && rd_req.addr < 16'h4000)
      |=> (rd_rsp.ram_sel && rd_rsp.rdata == $past(mem_rdata));
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read data wrong"); // see [R14]

  property p_even_lane;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && !rd_req.word && rd_req.addr < 16'h4000 && !rd_req.addr[0])
      |=> (rd_rsp.rdata == {8'h00, $past(mem_rdata[7:0])});
  endproperty
  a_even_lane: assert property (p_even_lane) else $error("even byte not on low lane"); // see [R15]

  property p_misaligned_read;
    @(posedge clk) disable iff (reset)
      (rd_req.valid && rd_req.word && rd_req.addr[0])
      |=> (addr_error_trap && rd_rsp.addr_error);
  endproperty
  a_misaligned_read: assert property (p_misaligned_read) else $error("odd word read not trapped"); // see [R16]

  property p_write_lane;
    @(posedge clk) disable iff (reset)
      (wr_req.valid && !wr_req.word && wr_req.addr < 16'h4000)
      |=> (mem_wbe == ($past(wr_req.addr[0]) ? 2'h2 : 2'h1));
  endproperty
  a_write_lane: assert property (p_write_lane) else $error("byte write lane wrong"); // see [R14]
endmodule : pdam_map

/* pdam_mem_model.sv */
module pdam_mem_model (
  input  wire logic [23:0] prog_addr,
  input  wire logic [15:0] mem_raddr,
  output logic      [23:0] prog_rdata,
  output logic      [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address-derived patterns, distinct per data location; program data uses prog_addr[15:0] only
  assign prog_rdata = {prog_addr[7:0] ^ 8'h5A, ~prog_addr[15:0]};
  assign mem_rdata  = mem_raddr ^ 16'hC33C;
endmodule : pdam_mem_model

/* pdam_map_test.sv */
module pdam_map_test;
  import pdam_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk, reset, step_fwd, step_back, load_ptr, table_op, prog_allowed, trap;
  logic [22:0]    load_target, ip;
  logic [7:0]     page;
  logic [15:0]    offset, mem_rdata, mem_raddr, mem_waddr, mem_wdata;
  logic [23:0]    prog_rdata, prog_addr, prog_data;
  logic [1:0]     prog_region, mem_wbe;
  pdam_data_req_t rd_req, wr_req;
  pdam_data_rsp_t rd_rsp;
  int             mismatches, comparisons, cycles;

  pdam_map dut (.clk(clk), .reset(reset), .step_fwd(step_fwd), .step_back(step_back),
    .load_ptr(load_ptr), .load_target(load_target), .table_op(table_op),
    .table_page_select(page), .table_offset(offset), .prog_rdata(prog_rdata),
    .rd_req(rd_req), .wr_req(wr_req), .mem_rdata(mem_rdata), .instruction_pointer(ip),
    .prog_addr(prog_addr), .prog_allowed(prog_allowed), .prog_region(prog_region),
    .prog_data(prog_data), .rd_rsp(rd_rsp), .mem_raddr(mem_raddr), .mem_waddr(mem_waddr),
    .mem_wbe(mem_wbe), .mem_wdata(mem_wdata), .addr_error_trap(trap));
  pdam_mem_model mem (.prog_addr(prog_addr), .mem_raddr(mem_raddr),
    .prog_rdata(prog_rdata), .mem_rdata(mem_rdata));

  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task t_pointer;
    @(posedge clk) load_ptr <= 1'b1;
    load_target <= 23'h000101;
    @(posedge clk) load_ptr <= 1'b0;
    step_fwd <= 1'b1;
    #1 chk(ip, 24'h000100);
    @(posedge clk) step_fwd <= 1'b0;
    step_back <= 1'b1;
    #1 chk(ip, 24'h000102);
    @(posedge clk) step_back <= 1'b0;
    #1 chk(ip, 24'h000100);
    chk(prog_addr, 24'h000100);
  endtask : t_pointer

  task t_prog(input logic [7:0] pg, input logic [15:0] off, input logic [1:0] rg,
              input logic al, input logic [23:0] dat);
    @(posedge clk) table_op <= 1'b1;
    page <= pg;
    offset <= off;
    #1 chk(prog_region, rg);
    chk(prog_allowed, al);
    @(posedge clk) table_op <= 1'b0;
    #1 chk(prog_data, dat);
  endtask : t_prog

  task t_acc(input logic rw, input logic [15:0] ra, input logic ww, input logic [15:0] wa,
             input logic [15:0] wd, input logic [3:0] fl, input logic [15:0] rd,
             input logic [1:0] be, input logic [15:0] wexp, input logic tr);
    @(posedge clk) rd_req <= '{1'b1, rw, ra, 16'h0000};
    wr_req <= '{1'b1, ww, wa, wd};
    #1 chk(mem_raddr, {ra[15:1], 1'b0});
    @(posedge clk) rd_req.valid <= 1'b0;
    wr_req.valid <= 1'b0;
    #1 chk({rd_rsp.ram_sel, rd_rsp.window_sel, rd_rsp.zero_fill, rd_rsp.addr_error}, fl);
    if (!fl[2])
      chk(rw ? rd_rsp.rdata : {8'h00, rd_rsp.rdata[7:0]}, rd);
    chk(mem_wbe, be);
    if (be != 2'h0)
      chk({mem_waddr, mem_wdata}, {wa[15:1], 1'b0, wexp});
    chk(trap, tr);
  endtask : t_acc

  initial
  begin
    {clk, step_fwd, step_back, load_ptr, table_op, page, offset, load_target} = '0;
    {rd_req, wr_req, mismatches, comparisons, cycles} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1 chk(ip, 24'h000000);
    chk(prog_addr, PDAM_RESET_VECTOR);
    t_pointer();
    t_prog(8'h00, 16'h0000, 2'h0, 1'b1, 24'h5AFFFF);
    t_prog(8'h00, 16'h0200, 2'h1, 1'b1, 24'h5AFDFF);
    t_prog(8'h00, 16'h0201, 2'h1, 1'b1, 24'h00005B);
    t_prog(8'h02, 16'hAC00, 2'h3, 1'b1, 24'h000000);
    t_prog(8'h80, 16'h0000, 2'h3, 1'b0, 24'h000000);
    t_prog(8'hF8, 16'h0000, 2'h2, 1'b1, 24'h5AFFFF);
    t_acc(1, 16'h0010, 0, 16'h0011, 16'h00AB, 4'h8, 16'hC32C, 2'h2, 16'hABAB, 0);
    t_acc(0, 16'h0011, 0, 16'h0020, 16'h0055, 4'h8, 16'h00C3, 2'h1, 16'h5555, 0);
    t_acc(0, 16'h0010, 1, 16'h0030, 16'h1234, 4'h8, 16'h002C, 2'h3, 16'h1234, 0);
    t_acc(1, 16'h4000, 1, 16'h4000, 16'h1111, 4'h2, 16'h0000, 2'h0, 16'h0000, 0);
    t_acc(0, 16'h4001, 0, 16'h3FFF, 16'h0077, 4'h2, 16'h0000, 2'h2, 16'h7777, 0);
    t_acc(1, 16'h8000, 1, 16'h8002, 16'h2222, 4'h4, 16'h0000, 2'h0, 16'h0000, 0);
    t_acc(1, 16'h0013, 0, 16'h0000, 16'h0000, 4'h9, 16'hC32E, 2'h1, 16'h0000, 1);
    t_acc(0, 16'h0002, 1, 16'h0021, 16'h3333, 4'h8, 16'h003E, 2'h0, 16'h0000, 1);
    give_verdict();
  end
endmodule : pdam_map_test
